// [include/aut_consts.vh]
// Purpose: constants of the address table command block
// Assumes: register numbers are used directly as addresses
// Notes: entry is {attr[8:0], mac_high[15:0], mac_low[31:0]}
`ifndef AUT_CONSTS_VH
`define AUT_CONSTS_VH

// register numbers
`define AUT_ADDR_CMD 16'h1800
`define AUT_ADDR_WR_LO 16'h1801
`define AUT_ADDR_WR_HI 16'h1802
`define AUT_ADDR_RD_LO 16'h1803
`define AUT_ADDR_RD_HI 16'h1804
`define AUT_ADDR_STS 16'h1805

// command bits
`define AUT_CMD_MAKE 2
`define AUT_CMD_FIRST 1
`define AUT_CMD_NEXT 0
`define AUT_CMD_RESET 3'h0

// status bits
`define AUT_STS_MAKE_PEND 0
`define AUT_STS_GET_PEND 1

// high data word fields
`define AUT_HI_VALID 24
`define AUT_HI_AGE 23
`define AUT_HI_STATIC 22
`define AUT_HI_PORT_MULTI 18
`define AUT_HI_MSB 24
`define AUT_DATA_RESET 32'h00000000

// table geometry
`define AUT_ENTRY_W 57
`define AUT_IDX_W 6
`define AUT_DEPTH 7'h40
`define AUT_E_VALID 56
`define AUT_E_AGE 55
`define AUT_E_STATIC 54

// aging sweep period
`define AUT_AGE_PERIOD_S 40'd300
`define AUT_CLK_HZ 40'd250000000
`define AUT_AGE_CYCLES (`AUT_AGE_PERIOD_S * `AUT_CLK_HZ)

`endif

// [design/aut_table_mem.v]
// Purpose: storage array of the address table
// Assumes: one write port, one asynchronous read port
// Notes: contents are undefined until the owner clears them
module aut_table_mem (
  // clock
  input wire sys_clk,
  // write port
  input wire we,
  input wire [5:0] waddr,
  input wire [56:0] wdata,
  // read port
  input wire [5:0] raddr,
  output wire [56:0] rdata
);

  reg [56:0] mem [0:63];

  always @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];

endmodule

// [design/aut_table_cmd.v]
// Purpose: software access to the address forwarding table
// Assumes: register port driven by logic on sys_clk
// Notes: table is cleared by a sweep after reset; commands wait for it
`include "aut_consts.vh"

// What this block does
// - a set make bit stores the staged two-word entry into the table
// - the table logic picks the slot: matching entry, else first free
// - make also overwrites or deletes an existing matching entry
// - writing zero to any command bit starts nothing
// - get first rewinds the pointer and loads the first valid entry
// - get next loads the next valid entry after the pointer
// - status register shows whether a make is still running
// - low write word holds first 32 mac bits, bit 0 multicast
// - valid bit 24 set makes entry valid; clear deletes the match
// - static entries never age; others expire after one to two periods if made with age bit 23 set, else at the next sweep
// - port field bits 18:16, bit 18 selects a port set
module aut_table_cmd #(
  parameter [39:0] AGE_CYCLES = `AUT_AGE_CYCLES
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata_r,
  output reg reg_rvalid_r
);

  localparam S_CLEAR = 3'd0;
  localparam S_IDLE = 3'd1;
  localparam S_MSCAN = 3'd2;
  localparam S_MWRITE = 3'd3;
  localparam S_GSCAN = 3'd4;
  localparam S_AGE = 3'd5;

  reg [2:0] state_r;
  reg [6:0] idx_r;
  reg [2:0] cmd_r;
  reg [31:0] wr_lo_r;
  reg [24:0] wr_hi_r;
  reg [31:0] rd_lo_r;
  reg [24:0] rd_hi_r;
  reg [6:0] rd_ptr_r;
  reg [6:0] get_from_r;
  reg make_pend_r;
  reg get_pend_r;
  reg hit_r;
  reg free_r;
  reg [5:0] hit_idx_r;
  reg [5:0] free_idx_r;
  reg [39:0] age_cnt_r;
  reg age_due_r;

  reg mem_we;
  reg [5:0] mem_waddr;
  reg [56:0] mem_wdata;
  wire [56:0] ent;
  wire [56:0] new_ent;
  wire at_end;
  wire cmd_wr;
  wire make_set;
  wire first_set;
  wire next_set;
  wire get_set;
  wire make_done;
  wire get_done;
  wire sweep_start;

  // fields kept as written, port set flag included
  assign new_ent = {wr_hi_r[`AUT_HI_MSB:16], wr_hi_r[15:0], wr_lo_r};
  assign at_end = (idx_r == `AUT_DEPTH);
  assign cmd_wr = reg_wr && (reg_addr == `AUT_ADDR_CMD);
  // only a 0 to 1 transition starts a command
  assign make_set = cmd_wr && reg_wdata[`AUT_CMD_MAKE] &&
                    !cmd_r[`AUT_CMD_MAKE];
  assign first_set = cmd_wr && reg_wdata[`AUT_CMD_FIRST] &&
                     !cmd_r[`AUT_CMD_FIRST];
  assign next_set = cmd_wr && reg_wdata[`AUT_CMD_NEXT] &&
                    !cmd_r[`AUT_CMD_NEXT];
  assign get_set = first_set || next_set;
  assign make_done = (state_r == S_MWRITE);
  assign get_done = (state_r == S_GSCAN) && (at_end || ent[`AUT_E_VALID]);
  assign sweep_start = (state_r == S_IDLE) && !make_pend_r &&
                       !get_pend_r && age_due_r;

  aut_table_mem u_mem (
    .sys_clk(sys_clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(idx_r[5:0]),
    .rdata(ent)
  );

  // table write port
  always @* begin
    mem_we = 1'b0;
    mem_waddr = idx_r[5:0];
    mem_wdata = {`AUT_ENTRY_W{1'b0}};
    case (state_r)
      S_CLEAR: begin
        mem_we = 1'b1;
      end
      S_MWRITE: begin
        // match wins over a free slot; clear valid only deletes
        mem_waddr = hit_r ? hit_idx_r : free_idx_r;
        mem_we = hit_r || (free_r && new_ent[`AUT_E_VALID]);
        // invalid write wipes the match, manual or learned
        mem_wdata = new_ent[`AUT_E_VALID] ? new_ent :
                    {`AUT_ENTRY_W{1'b0}};
      end
      S_AGE: begin
        // static entries are left alone
        if (!at_end && ent[`AUT_E_VALID] && !ent[`AUT_E_STATIC]) begin
          mem_we = 1'b1;
          if (ent[`AUT_E_AGE]) begin
            mem_wdata = ent &
                        ~({{(`AUT_ENTRY_W-1){1'b0}}, 1'b1} << `AUT_E_AGE);
          end
        end
      end
      default: begin
        mem_we = 1'b0;
      end
    endcase
  end

  // sequencer
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= S_CLEAR;
      idx_r <= 7'h00;
      hit_r <= 1'b0;
      free_r <= 1'b0;
      hit_idx_r <= 6'h00;
      free_idx_r <= 6'h00;
      rd_lo_r <= `AUT_DATA_RESET;
      rd_hi_r <= 25'h0000000;
      rd_ptr_r <= 7'h00;
    end else begin
      case (state_r)
        S_CLEAR: begin
          if (idx_r == `AUT_DEPTH - 7'h01) begin
            state_r <= S_IDLE;
            idx_r <= 7'h00;
          end else begin
            idx_r <= idx_r + 7'h01;
          end
        end
        S_IDLE: begin
          hit_r <= 1'b0;
          free_r <= 1'b0;
          if (make_pend_r) begin
            state_r <= S_MSCAN;
            idx_r <= 7'h00;
          end else if (get_pend_r) begin
            state_r <= S_GSCAN;
            idx_r <= get_from_r;
          end else if (age_due_r) begin
            state_r <= S_AGE;
            idx_r <= 7'h00;
          end
        end
        S_MSCAN: begin
          if (at_end) begin
            state_r <= S_MWRITE;
          end else if (ent[`AUT_E_VALID] && ent[47:0] == new_ent[47:0]) begin
            hit_r <= 1'b1;
            hit_idx_r <= idx_r[5:0];
            state_r <= S_MWRITE;
          end else begin
            if (!ent[`AUT_E_VALID] && !free_r) begin
              free_r <= 1'b1;
              free_idx_r <= idx_r[5:0];
            end
            idx_r <= idx_r + 7'h01;
          end
        end
        S_MWRITE: begin
          state_r <= S_IDLE;
        end
        S_GSCAN: begin
          // pointer parks at the end when nothing more is valid
          if (at_end) begin
            rd_lo_r <= `AUT_DATA_RESET;
            rd_hi_r <= 25'h0000000;
            rd_ptr_r <= idx_r;
            state_r <= S_IDLE;
          end else if (ent[`AUT_E_VALID]) begin
            rd_lo_r <= ent[31:0];
            rd_hi_r <= {ent[56:48], ent[47:32]};
            rd_ptr_r <= idx_r;
            state_r <= S_IDLE;
          end else begin
            idx_r <= idx_r + 7'h01;
          end
        end
        S_AGE: begin
          if (at_end) begin
            state_r <= S_IDLE;
          end else begin
            idx_r <= idx_r + 7'h01;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // software registers and pending flags; a new request beats completion
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cmd_r <= `AUT_CMD_RESET;
      wr_lo_r <= `AUT_DATA_RESET;
      wr_hi_r <= 25'h0000000;
      make_pend_r <= 1'b0;
      get_pend_r <= 1'b0;
      get_from_r <= 7'h00;
    end else begin
      if (cmd_wr) begin
        cmd_r <= reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == `AUT_ADDR_WR_LO) begin
        wr_lo_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == `AUT_ADDR_WR_HI) begin
        wr_hi_r <= reg_wdata[24:0];
      end
      // held from acceptance until the make write cycle or the get load cycle
      make_pend_r <= make_set || (make_pend_r && !make_done);
      get_pend_r <= get_set || (get_pend_r && !get_done);
      if (first_set) begin
        get_from_r <= 7'h00;
      end else if (next_set) begin
        get_from_r <= (rd_ptr_r == `AUT_DEPTH) ? `AUT_DEPTH :
                      rd_ptr_r + 7'h01;
      end
    end
  end

  // aging tick: two sweeps give an entry made with age bit 23 set one to two periods of life; one made with it clear goes at the next sweep
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      age_cnt_r <= 40'h0000000000;
      age_due_r <= 1'b0;
    end else begin
      if (age_cnt_r >= AGE_CYCLES - 40'h0000000001) begin
        age_cnt_r <= 40'h0000000000;
      end else begin
        age_cnt_r <= age_cnt_r + 40'h0000000001;
      end
      age_due_r <= (age_cnt_r >= AGE_CYCLES - 40'h0000000001) ||
                   (age_due_r && !sweep_start);
    end
  end

  // read port, one cycle latency, unmapped reads zero
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata_r <= 32'h00000000;
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `AUT_ADDR_CMD: reg_rdata_r <= {29'h00000000, cmd_r};
          `AUT_ADDR_WR_LO: reg_rdata_r <= wr_lo_r;
          `AUT_ADDR_WR_HI: reg_rdata_r <= {7'h00, wr_hi_r};
          `AUT_ADDR_RD_LO: reg_rdata_r <= rd_lo_r;
          `AUT_ADDR_RD_HI: reg_rdata_r <= {7'h00, rd_hi_r};
          `AUT_ADDR_STS: reg_rdata_r <= {30'h00000000, get_pend_r,
                                         make_pend_r};
          default: reg_rdata_r <= 32'h00000000;
        endcase
      end else begin
        reg_rdata_r <= 32'h00000000;
      end
    end
  end

endmodule

// [tb/aut_table_cmd_sva.sv]
// Purpose: port checks of the address table command block
// Assumes: command bits change only by register writes
// Notes: a shadow of the command bits marks a new command
module aut_table_cmd_sva (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata_r,
  input wire reg_rvalid_r
);
  reg [2:0] cmd_r;
  wire cwr = reg_wr && reg_addr == 16'h1800;
  wire srd = reg_rd && reg_addr == 16'h1805;
  always @(posedge sys_clk) begin
    if (sys_rst) cmd_r <= 3'h0;
    else if (cwr) cmd_r <= reg_wdata[2:0];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  rd_answer_a: assert property (reg_rd |=> reg_rvalid_r)
    else $error("read not answered");
  no_stray_a: assert property (!reg_rd |=> !reg_rvalid_r)
    else $error("answer without read");
  idle_zero_a: assert property (
    !reg_rvalid_r |-> reg_rdata_r == 32'h00000000)
    else $error("data outside answer");
  cmd_echo_a: assert property (
    reg_rd && reg_addr == 16'h1800 && !reg_wr
    |=> reg_rdata_r == {29'h00000000, $past(cmd_r)})
    else $error("command read back wrong");
  sts_rsvd_a: assert property (
    srd |=> reg_rdata_r[31:2] == 30'h00000000)
    else $error("status upper bits set");
  hi_rsvd_a: assert property (
    reg_rd && (reg_addr == 16'h1802 || reg_addr == 16'h1804)
    |=> reg_rdata_r[31:25] == 7'h00)
    else $error("high word upper bits set");
  make_pend_a: assert property (
    cwr && reg_wdata[2] && !cmd_r[2] ##1 srd |=> reg_rdata_r[0])
    else $error("make pending not raised");
  get_pend_a: assert property (
    cwr && reg_wdata[1] && !cmd_r[1] ##1 srd |=> reg_rdata_r[1])
    else $error("get pending not raised");
endmodule

bind aut_table_cmd aut_table_cmd_sva aut_table_cmd_sva_i (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r));

// [tb/tb.sv]
// Purpose: self-checking bench of the address table command
// Assumes: one-cycle strobes driven on the falling edge
// Notes: aging period cut to 200 cycles for a short run
module tb;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  fails++; $display("wrong value %s exp %h got %h", n, e, g); end end
  logic sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h00000000, d;
  wire [31:0] reg_rdata_r;
  wire reg_rvalid_r;
  int fails = 0, num_checks = 0;
  always #2 sys_clk = ~sys_clk;
  aut_table_cmd #(.AGE_CYCLES(40'h00000000C8)) aut_table_cmd_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r));
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr(input [15:0] a, input [31:0] v);
    @(negedge sys_clk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge sys_clk);
    reg_wr = 0;
  endtask
  task rd(input [15:0] a);
    @(negedge sys_clk);
    reg_rd = 1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 0;
    if (reg_rvalid_r !== 1'b1) begin
      fails++;
      give_verdict;
    end
    d = reg_rdata_r;
  endtask
  task poll(input int b);
    int n;
    for (n = 0; n < 400; n++) begin
      rd(16'h1805);
      if (d[b] === 1'b0) break;
    end
    if (n == 400) begin
      fails++;
      give_verdict;
    end
  endtask
  // status read in the very next cycle, before a short scan ends
  task cmd(input [31:0] c, input int b);
    @(negedge sys_clk);
    reg_wr = 1;
    reg_addr = 16'h1800;
    reg_wdata = c;
    @(negedge sys_clk);
    reg_wr = 0;
    reg_rd = 1;
    reg_addr = 16'h1805;
    @(negedge sys_clk);
    reg_rd = 0;
    `CHK("pending", 1'b1, reg_rdata_r[b])
    poll(b);
  endtask
  task make(input [31:0] hi, input [31:0] lo);
    wr(16'h1802, hi);
    wr(16'h1801, lo);
    cmd(32'h00000004, 0);
    wr(16'h1800, 32'h00000000);
  endtask
  task get(input [31:0] c, input [31:0] lo, input [31:0] hi);
    cmd(c, 1);
    wr(16'h1800, 32'h00000000);
    rd(16'h1803);
    `CHK("read low", lo, d)
    rd(16'h1804);
    `CHK("read high", hi, d)
  endtask
  task t_reset;
    rd(16'h1800);
    `CHK("command at reset", 32'h00000000, d)
    wr(16'h1800, 32'hFFFFFFF8);
    rd(16'h1800);
    `CHK("command", 32'h00000000, d)
    rd(16'h1806);
    `CHK("unmapped", 32'h00000000, d)
  endtask
  task t_make_get;
    make(32'hFF45AABB, 32'h11223345);
    make(32'h0142CCDD, 32'h66778800);
    get(32'h00000002, 32'h11223345, 32'h0145AABB);
    get(32'h00000001, 32'h66778800, 32'h0142CCDD);
    get(32'h00000001, 32'h00000000, 32'h00000000);
  endtask
  // read words sit on the second entry, so a stray get of either kind shows
  task t_modify;
    get(32'h00000002, 32'h11223345, 32'h0145AABB);
    get(32'h00000001, 32'h66778800, 32'h0142CCDD);
    wr(16'h1800, 32'h00000000);
    rd(16'h1805);
    `CHK("idle after zero", 32'h00000000, d)
    rd(16'h1803);
    `CHK("zero write", 32'h66778800, d)
    make(32'h0143AABB, 32'h11223345);
    get(32'h00000002, 32'h11223345, 32'h0143AABB);
    make(32'h0000AABB, 32'h11223345);
    get(32'h00000002, 32'h66778800, 32'h0142CCDD);
  endtask
  // aged entry needs two sweeps, so an early read is safe
  task t_age;
    make(32'h01800001, 32'h00000002);
    cmd(32'h00000002, 1);
    wr(16'h1800, 32'h00000000);
    rd(16'h1803);
    `CHK("free slot", 32'h00000002, d)
    repeat (600) @(negedge sys_clk);
    get(32'h00000002, 32'h66778800, 32'h0142CCDD);
  endtask
  initial begin
    repeat (16) @(negedge sys_clk);
    sys_rst = 0;
    t_reset;
    t_make_get;
    t_modify;
    t_age;
    give_verdict;
  end
endmodule
